// File: rtl/utc_cmd_apb.sv
// transmitter and receiver enable command decoding behind an APB slave
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module utc_cmd_apb
  import utc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [UTC_ADDR_W-1:0] paddr,
  input wire logic [UTC_DATA_W-1:0] pwdata,
  output logic [UTC_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_busy,
  input wire logic rx_busy,
  input wire logic tx_fifo_empty,
  input wire logic tx_fifo_write,
  input wire logic rx_coded_ready,
  input wire logic frame_sync_pin,
  output logic tx_enable,
  output logic rx_enable,
  output logic rx_search_start,
  output logic rx_discard,
  output logic tx_empty_flag,
  output logic tx_ready_flag
);
  logic [UTC_CFG_W-1:0] cfg_r;
  logic tx_en_r;
  logic tx_pend_r;
  logic rx_en_r;
  logic rx_pend_r;
  logic arm_r;
  logic fs_lvl;
  logic fs_prev_r;
  logic fs_rise;
  logic acc;
  logic cmd_wr;
  logic addr_ok;
  utc_cmd_t tx_cmd;
  utc_cmd_t rx_cmd;
  logic modem;
  logic ac97;
  logic rx_keep;
  logic ready_keep;

  function automatic logic utc_addr_hit(input logic [UTC_ADDR_W-1:0] a);
    utc_addr_hit = (a == UTC_OFS_COMMAND) || (a == UTC_OFS_CONFIG) || (a == UTC_OFS_STATUS);
  endfunction

  utc_sync3 u_fs_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(frame_sync_pin),
    .level_out(fs_lvl)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fs_prev_r <= 1'b0;
    else
      fs_prev_r <= fs_lvl;
  end
  assign fs_rise = fs_lvl && !fs_prev_r;

  // ---- APB slave: one wait-free access cycle, answer registered
  assign acc = psel && penable && pready;
  assign addr_ok = utc_addr_hit(paddr);
  assign cmd_wr = acc && pwrite && (paddr == UTC_OFS_COMMAND);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= psel && !penable;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else
      pslverr <= psel && !penable && !utc_addr_hit(paddr);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= UTC_RDATA_ZERO;
    else if (psel && !penable && !pwrite)
    begin
      prdata <= UTC_RDATA_ZERO;
      // command register reads back as zero: fields act only when written
      if (paddr == UTC_OFS_CONFIG)
        prdata[UTC_CFG_W-1:0] <= cfg_r;
      else if (paddr == UTC_OFS_STATUS)
      begin
        prdata[UTC_ST_TX_EMPTY_FLAG] <= tx_empty_flag;
        prdata[UTC_ST_TX_READY_FLAG] <= tx_ready_flag;
        prdata[UTC_ST_TXEN] <= tx_en_r;
        prdata[UTC_ST_RXEN] <= rx_en_r;
        prdata[UTC_ST_TXPEND] <= tx_pend_r;
        prdata[UTC_ST_RXPEND] <= rx_pend_r;
        prdata[UTC_ST_ARM] <= arm_r;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_r <= UTC_CFG_RESET;
    else if (acc && pwrite && addr_ok && (paddr == UTC_OFS_CONFIG))
      cfg_r <= pwdata[UTC_CFG_W-1:0];
  end

  assign modem = cfg_r[UTC_CFG_MODEM_BIT] || cfg_r[UTC_CFG_AC97_BIT];
  assign ac97 = cfg_r[UTC_CFG_AC97_BIT];
  assign rx_keep = (utc_chan_t'(cfg_r[UTC_CFG_CHAN_LSB +: 2]) == UTC_CHAN_LOCAL_LOOP)
    || (cfg_r[UTC_CFG_PM_LSB +: 2] == UTC_PM_MULTIDROP);
  assign ready_keep = modem
    && (utc_chan_t'(cfg_r[UTC_CFG_CHAN_LSB +: 2]) != UTC_CHAN_ECHO)
    && (utc_chan_t'(cfg_r[UTC_CFG_CHAN_LSB +: 2]) != UTC_CHAN_REMOTE_LOOP);

  // fields decoded only on the write edge; nothing of them is stored
  always_comb
  begin
    tx_cmd = UTC_CMD_NONE;
    rx_cmd = UTC_CMD_NONE;
    if (cmd_wr)
    begin
      tx_cmd = utc_cmd_t'(pwdata[UTC_TXC_LSB +: 2]);
      rx_cmd = utc_cmd_t'(pwdata[UTC_RXC_LSB +: 2]);
    end
  end

  // ---- transmitter enable; reserved code 11 falls into no branch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_en_r <= 1'b0;
      tx_pend_r <= 1'b0;
    end
    else if (tx_cmd == UTC_CMD_ENABLE && !tx_en_r)
    begin
      tx_en_r <= 1'b1;
      tx_pend_r <= 1'b0;
    end
    else if (tx_cmd == UTC_CMD_DISABLE && tx_en_r)
    begin
      tx_en_r <= 1'b0;
      tx_pend_r <= tx_busy;
    end
    else if (tx_pend_r && !tx_busy)
      tx_pend_r <= 1'b0;
  end

  // modem: empty waits for the first frame sync with no fifo load; codec: first such sync with code ready and fifo empty
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      arm_r <= 1'b0;
    else if (tx_cmd == UTC_CMD_ENABLE && !tx_en_r && modem)
      arm_r <= 1'b1;
    else if (tx_cmd == UTC_CMD_DISABLE || tx_fifo_write || (fs_rise && !ac97))
      arm_r <= 1'b0;
    else if (fs_rise && ac97 && rx_coded_ready && tx_fifo_empty)
      arm_r <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_empty_flag <= 1'b0;
    else if (tx_cmd == UTC_CMD_ENABLE && !tx_en_r && !modem)
      tx_empty_flag <= 1'b1;
    else if (arm_r && fs_rise && !tx_fifo_write && tx_en_r
      && (!ac97 || (rx_coded_ready && tx_fifo_empty)))
      tx_empty_flag <= 1'b1;
    else if (tx_cmd == UTC_CMD_DISABLE && tx_en_r)
      tx_empty_flag <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_ready_flag <= 1'b0;
    else if (tx_cmd == UTC_CMD_ENABLE && !tx_en_r && !modem)
      tx_ready_flag <= 1'b1;
    else if (tx_cmd == UTC_CMD_DISABLE && tx_en_r && !ready_keep)
      tx_ready_flag <= 1'b0;
  end

  // shifter keeps running until the character in flight is out
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_enable <= 1'b0;
    else
      tx_enable <= (tx_en_r || tx_pend_r) && !(tx_cmd == UTC_CMD_DISABLE && !tx_busy);
  end

  // ---- receiver enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_en_r <= 1'b0;
      rx_pend_r <= 1'b0;
    end
    else if (rx_cmd == UTC_CMD_ENABLE && !rx_en_r
      && cfg_r[UTC_CFG_PM_LSB +: 2] != UTC_PM_MULTIDROP)
    begin
      rx_en_r <= 1'b1;
      rx_pend_r <= 1'b0;
    end
    else if (rx_cmd == UTC_CMD_DISABLE && rx_en_r && !rx_keep)
    begin
      rx_en_r <= 1'b0;
      rx_pend_r <= modem && rx_busy;
    end
    else if (rx_pend_r && !rx_busy)
      rx_pend_r <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_search_start <= 1'b0;
    else
      rx_search_start <= rx_cmd == UTC_CMD_ENABLE && !rx_en_r
        && cfg_r[UTC_CFG_PM_LSB +: 2] != UTC_PM_MULTIDROP;
  end

  // only the partial character is dropped; status and control stay put
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_discard <= 1'b0;
    else
      rx_discard <= rx_cmd == UTC_CMD_DISABLE && rx_en_r && !rx_keep
        && !(modem && rx_busy);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_enable <= 1'b0;
    else if (rx_cmd == UTC_CMD_DISABLE && rx_en_r && !rx_keep)
      rx_enable <= modem && rx_busy;
    else if (rx_pend_r && !rx_busy)
      rx_enable <= 1'b0;
    else
      rx_enable <= rx_en_r || rx_pend_r || (rx_cmd == UTC_CMD_ENABLE && rx_search_start);
  end

  // ---- checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_tx_hold;
    (tx_cmd == UTC_CMD_NONE || tx_cmd == UTC_CMD_RSVD) |=> $stable(tx_en_r);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx state moved on no-op");

  property p_tx_en_flags;
    (tx_cmd == UTC_CMD_ENABLE && !tx_en_r && !modem) |=> (tx_empty_flag && tx_ready_flag);
  endproperty
  a_tx_en_flags: assert property (p_tx_en_flags) else $error("enable did not set flags");

  property p_modem_flags;
    (tx_cmd == UTC_CMD_ENABLE && modem && !fs_rise) |=> $stable(tx_ready_flag);
  endproperty
  a_modem_flags: assert property (p_modem_flags) else $error("modem enable moved ready");

  property p_tx_drain;
    (tx_cmd == UTC_CMD_DISABLE && tx_en_r && tx_busy) |=> (tx_enable && tx_pend_r);
  endproperty
  a_tx_drain: assert property (p_tx_drain) else $error("tx stopped mid character");

  property p_ready_keep;
    (tx_cmd == UTC_CMD_DISABLE && ready_keep && tx_ready_flag) |=> tx_ready_flag;
  endproperty
  a_ready_keep: assert property (p_ready_keep) else $error("modem disable cleared ready");

  property p_rx_hold;
    (rx_cmd == UTC_CMD_NONE || rx_cmd == UTC_CMD_RSVD) |=> $stable(rx_en_r);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx state moved on no-op");

  property p_rx_search;
    (rx_cmd == UTC_CMD_ENABLE && !rx_en_r && cfg_r[UTC_CFG_PM_LSB +: 2] != UTC_PM_MULTIDROP)
      |=> (rx_en_r && rx_search_start) ##1 (rx_enable && !rx_search_start);
  endproperty
  a_rx_search: assert property (p_rx_search) else $error("rx enable without search");

  property p_rx_off;
    (rx_cmd == UTC_CMD_DISABLE && rx_en_r && !rx_keep && !modem) |=> (!rx_enable && rx_discard);
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx disable not immediate");

  property p_rx_keep;
    (rx_cmd == UTC_CMD_DISABLE && rx_keep && rx_en_r) |=> rx_en_r;
  endproperty
  a_rx_keep: assert property (p_rx_keep) else $error("rx stopped in loop or multidrop");

  property p_rx_finish;
    (rx_cmd == UTC_CMD_DISABLE && rx_en_r && !rx_keep && modem && rx_busy) |=> rx_enable;
  endproperty
  a_rx_finish: assert property (p_rx_finish) else $error("modem rx cut mid character");

  // enable state may only move on the write edge itself
  property p_pulse;
    !cmd_wr |=> ($stable(tx_en_r) && $stable(rx_en_r));
  endproperty
  a_pulse: assert property (p_pulse) else $error("command acted outside write");
endmodule
`default_nettype wire

// File: rtl/utc_pkg.sv
// shared constants for the transmitter/receiver enable command block
package utc_pkg;
  localparam int unsigned UTC_ADDR_W = 8;
  localparam int unsigned UTC_DATA_W = 32;
  // register byte offsets
  localparam logic [UTC_ADDR_W-1:0] UTC_OFS_COMMAND = 8'h00;
  localparam logic [UTC_ADDR_W-1:0] UTC_OFS_CONFIG = 8'h04;
  localparam logic [UTC_ADDR_W-1:0] UTC_OFS_STATUS = 8'h08;
  // port_command fields
  localparam int unsigned UTC_TXC_LSB = 2;
  localparam int unsigned UTC_RXC_LSB = 0;
  localparam int unsigned UTC_CMD_W = 8;
  // config fields
  localparam int unsigned UTC_CFG_CHAN_LSB = 0;
  localparam int unsigned UTC_CFG_MODEM_BIT = 2;
  localparam int unsigned UTC_CFG_AC97_BIT = 3;
  localparam int unsigned UTC_CFG_PM_LSB = 4;
  localparam int unsigned UTC_CFG_W = 6;
  localparam logic [UTC_CFG_W-1:0] UTC_CFG_RESET = 6'h00;
  // status bit positions
  localparam int unsigned UTC_ST_TX_EMPTY_FLAG = 0;
  localparam int unsigned UTC_ST_TX_READY_FLAG = 1;
  localparam int unsigned UTC_ST_TXEN = 2;
  localparam int unsigned UTC_ST_RXEN = 3;
  localparam int unsigned UTC_ST_TXPEND = 4;
  localparam int unsigned UTC_ST_RXPEND = 5;
  localparam int unsigned UTC_ST_ARM = 6;
  localparam int unsigned UTC_ST_W = 7;
  localparam logic [UTC_DATA_W-1:0] UTC_RDATA_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    UTC_CMD_NONE = 2'h0,
    UTC_CMD_ENABLE = 2'h1,
    UTC_CMD_DISABLE = 2'h2,
    UTC_CMD_RSVD = 2'h3
  } utc_cmd_t;

  typedef enum logic [1:0] {
    UTC_CHAN_NORMAL = 2'h0,
    UTC_CHAN_ECHO = 2'h1,
    UTC_CHAN_LOCAL_LOOP = 2'h2,
    UTC_CHAN_REMOTE_LOOP = 2'h3
  } utc_chan_t;

  localparam logic [1:0] UTC_PM_MULTIDROP = 2'h3;
endpackage

// File: rtl/utc_sync3.sv
// three-stage synchroniser for a pin input, output moves when stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module utc_sync3
  import utc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin_in,
  output logic level_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end
    else
    begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a lone glitch through stage two never reaches the output
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      level_out <= 1'b0;
    else if (s2_r == s3_r)
      level_out <= s3_r;
  end
endmodule
`default_nettype wire

// File: test/uart_txrx_enable_command_tb_top.sv
// self-checking bench for the enable command block over APB
`timescale 1ns/1ns
`default_nettype none
module uart_txrx_enable_command_tb_top
  import utc_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [UTC_ADDR_W-1:0] paddr;
  logic [UTC_DATA_W-1:0] pwdata, prdata, r;
  logic tx_busy, rx_busy, tx_fifo_empty, tx_fifo_write, rx_coded_ready;
  logic frame_sync_pin, tx_enable, rx_enable, rx_search_start, rx_discard;
  logic tx_empty_flag, tx_ready_flag, tx_hold, rx_hold, code_ok, load, sync_go;
  logic saw_s, saw_d;
  logic [32:0] exp_q[$];
  logic [32:0] msk_q[$];
  int fail_count = 0;
  int checks_done = 0;
  int seed = 70576;
  int n;
  utc_cmd_apb u_dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .tx_busy(tx_busy),
    .rx_busy(rx_busy),
    .tx_fifo_empty(tx_fifo_empty),
    .tx_fifo_write(tx_fifo_write),
    .rx_coded_ready(rx_coded_ready),
    .frame_sync_pin(frame_sync_pin),
    .tx_enable(tx_enable),
    .rx_enable(rx_enable),
    .rx_search_start(rx_search_start),
    .rx_discard(rx_discard),
    .tx_empty_flag(tx_empty_flag),
    .tx_ready_flag(tx_ready_flag)
  );
  utc_far_model u_far (
    .pclk(pclk),
    .presetn(presetn),
    .tx_hold(tx_hold),
    .rx_hold(rx_hold),
    .code_ok(code_ok),
    .load(load),
    .sync_go(sync_go),
    .tx_busy(tx_busy),
    .rx_busy(rx_busy),
    .tx_fifo_empty(tx_fifo_empty),
    .tx_fifo_write(tx_fifo_write),
    .rx_coded_ready(rx_coded_ready),
    .frame_sync_pin(frame_sync_pin)
  );
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // called from the read monitor and the main sequence alike
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      fail_count++;
      give_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  // upper bits random: only the command byte may matter
  task wr(input logic [7:0] c);
    r = $random(seed);
    saw_s = 1'b0;
    saw_d = 1'b0;
    xfer(1'b1, UTC_OFS_COMMAND, {r[31:8], c});
  endtask
  task cfg(input logic [5:0] c);
    xfer(1'b1, UTC_OFS_CONFIG, {26'h0, c});
  endtask
  task rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    xfer(1'b0, a, 32'h0);
  endtask
  task st(input logic [3:0] e, input logic [3:0] m);
    rd(UTC_OFS_STATUS, {29'h0, e}, {29'h0, m});
  endtask
  task sync();
    sync_go <= 1'b1;
    @(posedge pclk);
    sync_go <= 1'b0;
    repeat (14) @(posedge pclk);
  endtask
  // takes a selector, not the pin: a value argument is copied once at the call
  task wait_fall(input logic rx_side);
    n = 0;
    while ((rx_side ? rx_enable : tx_enable) !== 1'b0 && n < 10)
    begin
      @(posedge pclk);
      n++;
    end
    if ((rx_side ? rx_enable : tx_enable) !== 1'b0)
    begin
      fail_count++;
      give_verdict();
    end
  endtask
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      cmp({pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());
  always @(posedge pclk)
  begin
    if (rx_search_start)
      saw_s = 1'b1;
    if (rx_discard)
      saw_d = 1'b1;
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    give_verdict();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, tx_hold, rx_hold, code_ok, load, sync_go} = 9'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    st(4'h0, 4'hF);
    rd(UTC_OFS_COMMAND, 33'h0, 33'h1FFFFFFFF);
    rd(UTC_OFS_CONFIG, 33'h0, 33'h1FFFFFFFF);
    rd(8'h0C, 33'h100000000, 33'h1FFFFFFFF);
    wr(8'h04);
    st(4'h7, 4'hF);
    wr(8'h00);
    st(4'h7, 4'hF);
    wr(8'h04);
    st(4'h7, 4'hF);
    wr(8'h01);
    cmp(saw_s, 1'b1);
    st(4'hF, 4'hF);
    wr(8'h01);
    cmp(saw_s, 1'b0);
    wr(8'h00);
    st(4'hF, 4'hF);
    tx_hold <= 1'b1;
    wr(8'h08);
    st(4'h0, 4'h3);
    cmp(tx_enable, 1'b1);
    tx_hold <= 1'b0;
    wait_fall(1'b0);
    cmp(tx_enable, 1'b0);
    wr(8'h02);
    cmp(saw_d, 1'b1);
    cmp(rx_enable, 1'b0);
    rd(UTC_OFS_CONFIG, 33'h0, 33'h3F);
    cfg(6'h02);
    wr(8'h01);
    wr(8'h02);
    cmp(rx_enable, 1'b1);
    cfg(6'h30);
    wr(8'h02);
    cmp(rx_enable, 1'b1);
    cfg(6'h00);
    wr(8'h02);
    cfg(6'h30);
    wr(8'h01);
    cmp(rx_enable, 1'b0);
    cfg(6'h00);
    wr(8'h05);
    st(4'hF, 4'hF);
    cfg(6'h04);
    wr(8'h08);
    st(4'h2, 4'h3);
    wr(8'h04);
    st(4'h2, 4'h3);
    sync();
    st(4'h3, 4'h3);
    cfg(6'h05);
    wr(8'h08);
    st(4'h0, 4'h3);
    rx_hold <= 1'b1;
    wr(8'h02);
    cmp(rx_enable, 1'b1);
    rx_hold <= 1'b0;
    wait_fall(1'b1);
    cmp(rx_enable, 1'b0);
    cmp(saw_d, 1'b0);
    cfg(6'h0C);
    wr(8'h04);
    sync();
    cmp(tx_empty_flag, 1'b0);
    code_ok <= 1'b1;
    wr(8'h08);
    wr(8'h04);
    sync();
    cmp(tx_empty_flag, 1'b1);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    st(4'h0, 4'hF);
    cfg(6'h04);
    wr(8'h04);
    load <= 1'b1;
    @(posedge pclk);
    load <= 1'b0;
    sync();
    cmp(tx_empty_flag, 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire

// File: test/utc_far_model.sv
// far-side model: line busy, tx fifo, codec ready code and frame sync pin
`timescale 1ns/1ns
`default_nettype none
module utc_far_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tx_hold,
  input wire logic rx_hold,
  input wire logic code_ok,
  input wire logic load,
  input wire logic sync_go,
  output logic tx_busy,
  output logic rx_busy,
  output logic tx_fifo_empty,
  output logic tx_fifo_write,
  output logic rx_coded_ready,
  output logic frame_sync_pin
);
  logic [2:0] sync_cnt_r;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      tx_busy <= 1'b0;
      rx_busy <= 1'b0;
      rx_coded_ready <= 1'b0;
      tx_fifo_write <= 1'b0;
      tx_fifo_empty <= 1'b1;
    end
    else
    begin
      tx_busy <= tx_hold;
      rx_busy <= rx_hold;
      rx_coded_ready <= code_ok;
      tx_fifo_write <= load;
      // no drain side here: once loaded it stays non-empty until reset
      tx_fifo_empty <= tx_fifo_empty && !load;
    end
  // pin held six cycles so the three-flop synchroniser surely sees it
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      sync_cnt_r <= 3'h0;
    else if (sync_go)
      sync_cnt_r <= 3'h6;
    else if (sync_cnt_r != 3'h0)
      sync_cnt_r <= sync_cnt_r - 3'h1;
  assign frame_sync_pin = sync_cnt_r != 3'h0;
endmodule
`default_nettype wire
